//--- bench/pb_link_checker.sv
`timescale 1ns/10ps
module pb_link_checker (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               pci_clk,
  input  wire pb_pkg::pb_bus_s    dev_o,
  input  wire pb_pkg::pb_bus_s    dev_oe,
  input  wire pb_pkg::pb_bus_s    hst_o,
  input  wire pb_pkg::pb_bus_s    hst_oe,
  input  wire pb_pkg::pb_bus_s    bus,
  input  wire logic               idsel,
  input  wire logic [3:1]         req_n,
  input  wire logic [3:1]         gnt_n
);
  import pb_pkg::*;

  // Pins float and grants stay off through reset
  reset_float_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> $past(dev_oe) == '0 && $past(hst_oe) == '0 && $past(gnt_n) == 3'h7)
    else $error("pins driven during reset");
  // System error line only ever pulled low
  serr_drain_a: assert property (@(posedge clk) disable iff (!rst_b)
    dev_oe.serr_n |-> !dev_o.serr_n) else $error("serr driven high");
  // Target ready only while claiming
  trdy_claim_a: assert property (@(posedge clk) disable iff (!rst_b)
    dev_oe.trdy_n && !dev_o.trdy_n |-> dev_oe.devsel_n && !dev_o.devsel_n)
    else $error("trdy without devsel");
  // Stop only while claiming
  stop_claim_a: assert property (@(posedge clk) disable iff (!rst_b)
    dev_oe.stop_n && !dev_o.stop_n |-> !dev_o.devsel_n) else $error("stop without devsel");
  // Single data phase: frame leaves as irdy arrives
  frame_irdy_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(bus.irdy_n) |-> !$past(bus.frame_n) && bus.frame_n) else $error("frame and irdy out of step");
  // Never two drivers on address/data
  ad_owner_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(dev_oe.ad[0] && hst_oe.ad[0])) else $error("ad contention");
  // Device parity one link clock after its data
  par_dev_a: assert property (@(posedge pci_clk) disable iff (!rst_b)
    $past(dev_oe.ad[0]) |-> dev_oe.par && bus.par == ^{$past(bus.ad), $past(bus.cbe_n)})
    else $error("device parity wrong");
  // Host parity one link clock after its address/data
  par_host_a: assert property (@(posedge pci_clk) disable iff (!rst_b)
    $past(hst_oe.ad[0]) |-> hst_oe.par && bus.par == ^{$past(bus.ad), $past(bus.cbe_n)})
    else $error("host parity wrong");
  // At most one grant, none to idle request lines
  grant_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(~gnt_n) && gnt_n[3:2] == 2'h3) else $error("bad grant");
  // Clean pair never reports errors
  no_error_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus.perr_n && bus.serr_n) else $error("false error report");
endmodule : pb_link_checker

//--- bench/test_pci_bus_signalling.sv
`timescale 1ns/10ps
module test_pci_bus_signalling;
  import pb_pkg::*;
  localparam logic [31:0] RD_WORD = 32'h1234_5678;
  typedef struct packed {
    logic        wr;
    logic        cfg;
    logic [31:0] addr;
    logic [31:0] data;
    pb_stat_e    stat;
    logic [31:0] exp;
  } pb_row_s;
  logic        clk, rst_b, en, wr_ready, ini_valid, cmd_valid, cmd_write, cmd_cfg;
  logic [31:0] ini_addr, ini_data, cmd_addr, cmd_data, wr_data, rsp_data, cfg_reg;
  logic        wr_valid, ini_busy, ini_done, cmd_busy, rsp_valid, en_leak;
  pb_stat_e    ini_stat, rsp_stat;
  int          failures, checks, n;
  logic [31:0] wq[$];
  pb_row_s     rows[7];
  pb_link_if   lk();

  pb_dev_end pb_dev_end_inst (.clk(clk), .rst_b(rst_b), .pb(lk.dev), .en(en), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(RD_WORD), .ini_valid(ini_valid),
    .ini_addr(ini_addr), .ini_data(ini_data), .ini_busy(ini_busy), .ini_done(ini_done),
    .ini_stat(ini_stat), .cfg_reg(cfg_reg));
  pb_host_end pb_host_end_inst (.clk(clk), .rst_b(rst_b), .pb(lk.hst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_cfg(cmd_cfg), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_stat(rsp_stat));
  pb_link_checker pb_link_checker_inst (.clk(clk), .rst_b(rst_b), .pci_clk(lk.pci_clk),
    .dev_o(lk.dev_o), .dev_oe(lk.dev_oe), .hst_o(lk.hst_o), .hst_oe(lk.hst_oe), .bus(lk.bus),
    .idsel(lk.idsel), .req_n(lk.req_n), .gnt_n(lk.gnt_n));

  // Core clock
  always #2.5 clk = ~clk;
  // Link clock, offset from the core clock
  initial begin
    lk.pci_clk = 1'h0;
    #3;
    forever #80 lk.pci_clk = ~lk.pci_clk;
  end
  // Collect words leaving the write buffer
  always @(posedge clk) begin
    if (rst_b && wr_valid && wr_ready) wq.push_back(wr_data);
    if (rst_b && !en && |lk.dev_oe) en_leak <= 1'h1;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_stat(input pb_stat_e got, input pb_stat_e exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: status %0d expected %0d", $time, got, exp);
    end
  endtask : chk_stat

  // One host command, waits for its response pulse
  task automatic host_op(input pb_row_s r);
    for (n = 0; n < 4000 && cmd_busy !== 1'h0; n++) @(negedge clk);
    cmd_valid = 1'h1;
    cmd_write = r.wr;
    cmd_cfg   = r.cfg;
    cmd_addr  = r.addr;
    cmd_data  = r.data;
    @(negedge clk);
    cmd_valid = 1'h0;
    for (n = 0; n < 4000 && rsp_valid !== 1'h1; n++) @(negedge clk);
    if (rsp_valid !== 1'h1) begin
      failures++;
      $display("mismatch at %0t: no host response", $time);
    end
  endtask : host_op

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog
  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  // Main sequence
  initial begin
    clk = 1'h0; rst_b = 1'h0; en = 1'h1; wr_ready = 1'h1; ini_valid = 1'h0; cmd_valid = 1'h0;
    cmd_write = 1'h0; cmd_cfg = 1'h0; cmd_addr = 32'h0; cmd_data = 32'h0; en_leak = 1'h0;
    ini_addr = 32'h0; ini_data = 32'h0; failures = 0; checks = 0;
    rows = '{'{1'h1, 1'h0, 32'h8000_0010, 32'hA5A5_0001, PB_ST_OK, 32'h0},
             '{1'h0, 1'h0, 32'h8000_FFFC, 32'h0, PB_ST_OK, RD_WORD},
             '{1'h1, 1'h1, 32'h0000_0000, 32'hCAFE_0042, PB_ST_OK, 32'h0},
             '{1'h0, 1'h1, 32'h0000_0000, 32'h0, PB_ST_OK, 32'hCAFE_0042},
             '{1'h1, 1'h0, 32'h8001_0000, 32'h0000_0001, PB_ST_ABORT, 32'h0},
             '{1'h0, 1'h1, 32'h0000_0001, 32'h0, PB_ST_ABORT, 32'h0},
             '{1'h0, 1'h0, 32'h7FFF_FFFC, 32'h0, PB_ST_ABORT, 32'h0}};
    repeat (6) @(negedge clk);
    chk_word(32'(|{lk.dev_oe, lk.hst_oe}), 32'h0);
    chk_word(32'(lk.gnt_n), 32'h0000_0007);
    rst_b = 1'h1;
    chk_word(cfg_reg, PB_CFG_RST);
    foreach (rows[i]) begin
      host_op(rows[i]);
      chk_stat(rsp_stat, rows[i].stat);
      if (!rows[i].wr && rows[i].stat == PB_ST_OK) chk_word(rsp_data, rows[i].exp);
      if (rows[i].wr && !rows[i].cfg && rows[i].stat == PB_ST_OK) chk_word(wq.pop_front(), rows[i].data);
    end
    // Fill the buffer until refused, then drain it
    wr_ready = 1'h0;
    for (int k = 0; k < 3; k++) begin
      host_op('{1'h1, 1'h0, 32'h8000_0100, 32'hB000_0000 + k, PB_ST_OK, 32'h0});
      chk_stat(rsp_stat, k < 2 ? PB_ST_OK : PB_ST_RETRY);
    end
    wr_ready = 1'h1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 2; k++) chk_word(wq.size() > 0 ? wq.pop_front() : 32'h0, 32'hB000_0000 + k);
    chk_word(32'(wr_valid), 32'h0);
    // Device as initiator: nobody claims, so it gives up
    ini_addr  = 32'h4000_0000;
    ini_data  = 32'h5A5A_5A5A;
    ini_valid = 1'h1;
    @(negedge clk);
    ini_valid = 1'h0;
    for (n = 0; n < 4000 && ini_done !== 1'h1; n++) @(negedge clk);
    chk_word(32'(ini_done), 32'h1);
    chk_stat(ini_stat, PB_ST_ABORT);
    @(negedge clk);
    chk_word(32'(ini_busy), 32'h0);
    // Controller disabled: no grant, so the host write waits untouched
    en        = 1'h0;
    cmd_valid = 1'h1;
    cmd_write = 1'h1;
    cmd_cfg   = 1'h0;
    cmd_addr  = 32'h8000_0000;
    cmd_data  = 32'h0000_0001;
    @(negedge clk);
    cmd_valid = 1'h0;
    repeat (400) @(negedge clk);
    chk_word(32'(cmd_busy), 32'h1);
    chk_word(32'(en_leak), 32'h0);
    // Enabled again: the waiting write is granted and lands
    en = 1'h1;
    for (n = 0; n < 4000 && rsp_valid !== 1'h1; n++) @(negedge clk);
    chk_stat(rsp_stat, PB_ST_OK);
    repeat (4) @(negedge clk);
    chk_word(wq.size() > 0 ? wq.pop_front() : 32'h0, 32'h0000_0001);
    host_op('{1'h0, 1'h1, 32'h0000_0000, 32'h0, PB_ST_OK, 32'h0});
    chk_word(rsp_data, 32'hCAFE_0042);
    wrap_up();
  end
endmodule : test_pci_bus_signalling

//--- hw/pb_dev_end.sv
`timescale 1ns/10ps
// Overview of operation
// - AD carries address, then data words
// - CBE carries command, then byte enables
// - PAR is parity over AD and CBE
// - Initiator frames transaction, drops before last phase
// - Target asserts TRDY only when able
// - Initiator asserts IRDY when ready to transfer
// - Target STOP asks initiator to terminate
// - Data receiver flags parity mismatch on PERR
// - SERR flags address or special-cycle parity errors
// - SERR is open-drain, never driven high
// - Device drives DEVSEL when claiming an address
// - Device initiator samples DEVSEL for a claim
// - Configuration cycles claimed only with IDSEL high
// - Three request inputs feed the internal arbiter
// - Arbiter drives three matching grant outputs
// - Bus sampled on rising link clock edges
module pb_dev_end (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  pb_link_if.dev                             pb,
  input  wire logic                          en,
  output logic     [pb_pkg::PB_AD_W-1:0]     wr_data,
  output logic                               wr_valid,
  input  wire logic                          wr_ready,
  input  wire logic [pb_pkg::PB_AD_W-1:0]    rd_data,
  input  wire logic                          ini_valid,
  input  wire logic [pb_pkg::PB_AD_W-1:0]    ini_addr,
  input  wire logic [pb_pkg::PB_AD_W-1:0]    ini_data,
  output logic                               ini_busy,
  output logic                               ini_done,
  output pb_pkg::pb_stat_e                   ini_stat,
  output logic     [pb_pkg::PB_AD_W-1:0]     cfg_reg
);
  import pb_pkg::*;

  typedef enum logic [3:0] {T_IDLE = 4'h1, T_DATA = 4'h2, T_TURN = 4'h4, T_SPEC = 4'h8} pb_tst_e;
  typedef enum logic [3:0] {M_IDLE = 4'h1, M_ADDR = 4'h2, M_DATA = 4'h4, M_TURN = 4'h8} pb_mst_e;

  logic [PB_IN_W-1:0]  s1_q, s2_q, s3_q;
  pb_bus_s             bs;
  logic [PB_REQ_W-1:0] req_n, rq;
  logic                idsel, lclk_q, idl_q;
  logic                edge_w, idle_w, addr_w, cfg_w, hit_w, xfer_w, push_w, room_w, tdone_w, spec_w;
  pb_tst_e             tst_q;
  pb_mst_e             mst_q;
  logic [PB_AD_W-1:0]  ad_q, iaddr_q, idata_q, d0_q, d1_q;
  logic [3:0]          cbe_q;
  logic [2:0]          wait_q, gnt_q;
  pb_stat_e            stat_q;
  logic                ad_oe_q, cbe_oe_q, frame_q, irdy_q, mctl_oe_q, devsel_q, trdy_q, stop_q, tctl_oe_q;
  logic                par_q, par_oe_q, perr_q, perr_oe_q, serr_oe_q, chk_q, chk_par_q, chk_serr_q;
  logic                wr_q, cfgc_q, rdf_q, own_q, busy_q, done_q, v0_q, v1_q;

  // Three-stage pin synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= {pb.pci_clk, pb.idsel, pb.req_n, pb.bus};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Link clock level and bus idle history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lclk_q <= 1'b0;
      idl_q  <= 1'b1;
    end else begin
      if (s2_q[PB_IN_CK] == s3_q[PB_IN_CK]) lclk_q <= s3_q[PB_IN_CK];
      if (edge_w) idl_q <= idle_w;
    end
  end

  // Sampled view and decode
  assign bs      = s3_q[PB_BUS_W-1:0];
  assign req_n   = s3_q[PB_BUS_W+PB_REQ_W-1:PB_BUS_W];
  assign idsel   = s3_q[PB_IN_ID];
  assign edge_w  = s2_q[PB_IN_CK] & s3_q[PB_IN_CK] & ~lclk_q;
  assign idle_w  = bs.frame_n & bs.irdy_n;
  assign addr_w  = edge_w & ~bs.frame_n & idl_q & (tst_q == T_IDLE) & (mst_q == M_IDLE);
  assign cfg_w   = ((bs.cbe_n == PB_CMD_CFG_RD) | (bs.cbe_n == PB_CMD_CFG_WR)) & idsel
                   & (bs.ad[1:0] == PB_CFG_TYP0);
  assign hit_w   = en & (cfg_w | (((bs.cbe_n == PB_CMD_MEM_RD) | (bs.cbe_n == PB_CMD_MEM_WR))
                   & (bs.ad[PB_AD_W-1:PB_BAR_LSB] == PB_BAR_HI)));
  assign xfer_w  = edge_w & (tst_q == T_DATA) & ~bs.irdy_n & ~trdy_q;
  assign push_w  = xfer_w & wr_q & ~cfgc_q;
  assign room_w  = push_w ? ~v0_q : ~v1_q;
  assign tdone_w = edge_w & (tst_q == T_DATA) & (idle_w | (~bs.irdy_n & bs.frame_n & ~(trdy_q & stop_q)));
  assign spec_w  = edge_w & (tst_q == T_SPEC) & ~bs.irdy_n;
  assign rq      = ~req_n;

  // Target and initiator state with their bus pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b || !en) begin
      tst_q <= T_IDLE;
      mst_q <= M_IDLE;
      ad_oe_q <= 1'b0;
      cbe_oe_q <= 1'b0;
      mctl_oe_q <= 1'b0;
      tctl_oe_q <= 1'b0;
      {frame_q, irdy_q, devsel_q, trdy_q, stop_q} <= '1;
      {wr_q, cfgc_q, rdf_q} <= '0;
      ad_q <= '0;
      cbe_q <= PB_BE_ALL;
      wait_q <= '0;
      stat_q <= PB_ST_OK;
    end else if (edge_w) begin
      case (tst_q)
        T_IDLE: begin
          if (addr_w && hit_w) begin
            tst_q <= T_DATA;
            wr_q <= bs.cbe_n[PB_CMD_WR_BIT];
            cfgc_q <= cfg_w;
            rdf_q <= ~bs.cbe_n[PB_CMD_WR_BIT];
            tctl_oe_q <= 1'b1;
            devsel_q <= 1'b0;
            trdy_q <= ~(bs.cbe_n[PB_CMD_WR_BIT] & (cfg_w | room_w));
            stop_q <= ~(bs.cbe_n[PB_CMD_WR_BIT] & ~cfg_w & ~room_w);
          end else if (addr_w && bs.cbe_n == PB_CMD_SPECIAL) begin
            tst_q <= T_SPEC;
          end
        end
        T_DATA: begin
          if (tdone_w) begin
            tst_q <= T_TURN;
            {devsel_q, trdy_q, stop_q} <= '1;
            ad_oe_q <= 1'b0;
          end else if (rdf_q) begin
            rdf_q <= 1'b0;
            trdy_q <= 1'b0;
            ad_q <= cfgc_q ? cfg_reg : rd_data;
            ad_oe_q <= 1'b1;
          end else if (wr_q) begin
            stop_q <= stop_q & (cfgc_q | room_w);
            trdy_q <= ~(stop_q & (cfgc_q | room_w));
          end else if (xfer_w) begin
            ad_q <= cfgc_q ? cfg_reg : rd_data;
          end
        end
        T_TURN: begin
          tctl_oe_q <= 1'b0;
          tst_q <= T_IDLE;
        end
        T_SPEC: if (~bs.irdy_n || idle_w) tst_q <= T_IDLE;
        default: tst_q <= T_IDLE;
      endcase
      case (mst_q)
        M_IDLE: begin
          if (busy_q && !done_q && own_q && idle_w && tst_q == T_IDLE) begin
            mst_q <= M_ADDR;
            mctl_oe_q <= 1'b1;
            frame_q <= 1'b0;
            irdy_q <= 1'b1;
            ad_q <= iaddr_q;
            ad_oe_q <= 1'b1;
            cbe_q <= PB_CMD_MEM_WR;
            cbe_oe_q <= 1'b1;
          end
        end
        M_ADDR: begin
          mst_q <= M_DATA;
          frame_q <= 1'b1;
          irdy_q <= 1'b0;
          ad_q <= idata_q;
          cbe_q <= PB_BE_ALL;
          wait_q <= '0;
        end
        M_DATA: begin
          if (!bs.trdy_n || !bs.stop_n || (bs.devsel_n && wait_q == PB_DEVSEL_WAIT)) begin
            mst_q <= M_TURN;
            irdy_q <= 1'b1;
            ad_oe_q <= 1'b0;
            cbe_oe_q <= 1'b0;
            stat_q <= !bs.trdy_n ? PB_ST_OK : (!bs.stop_n ? PB_ST_RETRY : PB_ST_ABORT);
          end else if (bs.devsel_n) begin
            wait_q <= wait_q + 3'h1;
          end
        end
        M_TURN: begin
          mctl_oe_q <= 1'b0;
          mst_q <= M_IDLE;
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // Parity drive and parity checking
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {par_q, par_oe_q, perr_oe_q, serr_oe_q, chk_q, chk_par_q, chk_serr_q} <= '0;
      perr_q <= 1'b1;
    end else if (edge_w) begin
      par_oe_q <= ad_oe_q & en;
      par_q <= pb_parity(ad_q, cbe_oe_q ? cbe_q : bs.cbe_n);
      chk_q <= en & (addr_w | (xfer_w & wr_q) | spec_w);
      chk_par_q <= pb_parity(bs.ad, bs.cbe_n);
      chk_serr_q <= addr_w | spec_w;
      perr_oe_q <= en & chk_q & ~chk_serr_q;
      perr_q <= ~(chk_q & ~chk_serr_q & (bs.par != chk_par_q));
      serr_oe_q <= en & chk_q & chk_serr_q & (bs.par != chk_par_q);
    end
  end

  // Arbiter: lowest request index wins, regrant only on idle bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b || !en) begin
      gnt_q <= PB_REQ_IDLE;
      own_q <= 1'b0;
    end else if (edge_w && idle_w && mst_q == M_IDLE) begin
      gnt_q <= ~(rq & (~rq + 3'h1));
      own_q <= ~|rq;
    end
  end

  // Two-entry write buffer, head in slot 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {v0_q, v1_q} <= '0;
      d0_q <= '0;
      d1_q <= '0;
    end else begin
      if (v0_q && wr_ready) begin
        d0_q <= d1_q;
        v0_q <= v1_q;
        v1_q <= 1'b0;
      end
      if (push_w) begin
        if (!v0_q || (wr_ready && !v1_q)) begin
          d0_q <= bs.ad;
          v0_q <= 1'b1;
        end else begin
          d1_q <= bs.ad;
          v1_q <= 1'b1;
        end
      end
    end
  end

  // User initiator request and completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      iaddr_q <= '0;
      idata_q <= '0;
    end else begin
      done_q <= edge_w & (mst_q == M_TURN);
      if (ini_valid && !busy_q) begin
        busy_q <= 1'b1;
        iaddr_q <= ini_addr;
        idata_q <= ini_data;
      end else if (done_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Configuration scratch word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cfg_reg <= PB_CFG_RST;
    else if (xfer_w && wr_q && cfgc_q) cfg_reg <= bs.ad;
  end

  assign pb.dev_o  = '{ad: ad_q, cbe_n: cbe_q, par: par_q, frame_n: frame_q, irdy_n: irdy_q, trdy_n: trdy_q,
                       stop_n: stop_q, devsel_n: devsel_q, perr_n: perr_q, serr_n: 1'b0};
  assign pb.dev_oe = '{ad: {PB_AD_W{ad_oe_q}}, cbe_n: {PB_CBE_W{cbe_oe_q}}, par: par_oe_q, frame_n: mctl_oe_q,
                       irdy_n: mctl_oe_q, trdy_n: tctl_oe_q, stop_n: tctl_oe_q, devsel_n: tctl_oe_q,
                       perr_n: perr_oe_q, serr_n: serr_oe_q};
  assign pb.gnt_n  = gnt_q;
  assign wr_data   = d0_q;
  assign wr_valid  = v0_q;
  assign ini_busy  = busy_q;
  assign ini_done  = done_q;
  assign ini_stat  = stat_q;
endmodule : pb_dev_end

//--- hw/pb_host_end.sv
`timescale 1ns/10ps
module pb_host_end (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  pb_link_if.hst                             pb,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_write,
  input  wire logic                          cmd_cfg,
  input  wire logic [pb_pkg::PB_AD_W-1:0]    cmd_addr,
  input  wire logic [pb_pkg::PB_AD_W-1:0]    cmd_data,
  output logic                               cmd_busy,
  output logic                               rsp_valid,
  output logic     [pb_pkg::PB_AD_W-1:0]     rsp_data,
  output pb_pkg::pb_stat_e                   rsp_stat
);
  import pb_pkg::*;

  localparam int HW = PB_BUS_W + PB_REQ_W + 1;
  typedef enum logic [4:0] {H_IDLE = 5'h01, H_REQ = 5'h02, H_ADDR = 5'h04, H_DATA = 5'h08, H_TURN = 5'h10} pb_hst_e;

  logic [HW-1:0]      s1_q, s2_q, s3_q;
  pb_bus_s            bs;
  logic [2:0]         gnt_n, req_q, wait_q;
  logic               lclk_q, edge_w, idle_w, mis_w;
  pb_hst_e            st_q;
  logic [PB_AD_W-1:0] ad_q, addr_q, data_q;
  logic [3:0]         cbe_q;
  logic               wr_q, cfg_q, busy_q, ad_oe_q, cbe_oe_q, ctl_oe_q, frame_q, irdy_q, idsel_q;
  logic               par_q, par_oe_q, perr_q, perr_oe_q, chk_q, chk_par_q, rv_q;
  pb_stat_e           stat_q, rst_q;

  // Three-stage pin synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= {pb.pci_clk, pb.gnt_n, pb.bus};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Link clock level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lclk_q <= 1'b0;
    else if (s2_q[HW-1] == s3_q[HW-1]) lclk_q <= s3_q[HW-1];
  end

  assign bs     = s3_q[PB_BUS_W-1:0];
  assign gnt_n  = s3_q[HW-2:PB_BUS_W];
  assign edge_w = s2_q[HW-1] & s3_q[HW-1] & ~lclk_q;
  assign idle_w = bs.frame_n & bs.irdy_n;
  assign mis_w  = chk_q & (bs.par != chk_par_q);

  // Command capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      {wr_q, cfg_q} <= '0;
      addr_q <= '0;
      data_q <= '0;
    end else if (cmd_valid && !busy_q) begin
      busy_q <= 1'b1;
      wr_q <= cmd_write;
      cfg_q <= cmd_cfg;
      addr_q <= cmd_addr;
      data_q <= cmd_data;
    end else if (rv_q) begin
      busy_q <= 1'b0;
    end
  end

  // Initiator sequence and its bus pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= H_IDLE;
      req_q <= PB_REQ_IDLE;
      {ad_oe_q, cbe_oe_q, ctl_oe_q, idsel_q} <= '0;
      {frame_q, irdy_q} <= '1;
      ad_q <= '0;
      cbe_q <= PB_BE_ALL;
      wait_q <= '0;
      stat_q <= PB_ST_OK;
      rsp_data <= '0;
    end else if (edge_w) begin
      case (st_q)
        H_IDLE: begin
          if (busy_q && !rv_q) begin
            st_q <= H_REQ;
            req_q <= PB_REQ_ONE;
          end
        end
        H_REQ: begin
          if (!gnt_n[0] && idle_w) begin
            st_q <= H_ADDR;
            req_q <= PB_REQ_IDLE;
            ctl_oe_q <= 1'b1;
            frame_q <= 1'b0;
            ad_q <= addr_q;
            ad_oe_q <= 1'b1;
            cbe_q <= cfg_q ? (wr_q ? PB_CMD_CFG_WR : PB_CMD_CFG_RD) : (wr_q ? PB_CMD_MEM_WR : PB_CMD_MEM_RD);
            cbe_oe_q <= 1'b1;
            idsel_q <= cfg_q;
          end
        end
        H_ADDR: begin
          st_q <= H_DATA;
          frame_q <= 1'b1;
          irdy_q <= 1'b0;
          cbe_q <= PB_BE_ALL;
          idsel_q <= 1'b0;
          ad_q <= data_q;
          ad_oe_q <= wr_q;
          wait_q <= '0;
        end
        H_DATA: begin
          if (!bs.trdy_n || !bs.stop_n || (bs.devsel_n && wait_q == PB_DEVSEL_WAIT)) begin
            st_q <= H_TURN;
            irdy_q <= 1'b1;
            ad_oe_q <= 1'b0;
            cbe_oe_q <= 1'b0;
            rsp_data <= bs.ad;
            stat_q <= !bs.trdy_n ? PB_ST_OK : (!bs.stop_n ? PB_ST_RETRY : PB_ST_ABORT);
          end else if (bs.devsel_n) begin
            wait_q <= wait_q + 3'h1;
          end
        end
        H_TURN: begin
          st_q <= H_IDLE;
          ctl_oe_q <= 1'b0;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Parity drive and read-data check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {par_q, par_oe_q, perr_oe_q, chk_q, chk_par_q} <= '0;
      perr_q <= 1'b1;
    end else if (edge_w) begin
      par_oe_q <= ad_oe_q;
      par_q <= pb_parity(ad_q, cbe_oe_q ? cbe_q : bs.cbe_n);
      chk_q <= (st_q == H_DATA) & ~wr_q & ~bs.trdy_n;
      chk_par_q <= pb_parity(bs.ad, bs.cbe_n);
      perr_oe_q <= chk_q;
      perr_q <= ~mis_w;
    end
  end

  // Response pulse after turnaround
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rv_q <= 1'b0;
      rst_q <= PB_ST_OK;
    end else begin
      rv_q <= edge_w & (st_q == H_TURN);
      if (edge_w && st_q == H_TURN) rst_q <= mis_w ? PB_ST_PERR : stat_q;
    end
  end

  assign pb.hst_o  = '{ad: ad_q, cbe_n: cbe_q, par: par_q, frame_n: frame_q, irdy_n: irdy_q, trdy_n: 1'b1,
                       stop_n: 1'b1, devsel_n: 1'b1, perr_n: perr_q, serr_n: 1'b1};
  assign pb.hst_oe = '{ad: {PB_AD_W{ad_oe_q}}, cbe_n: {PB_CBE_W{cbe_oe_q}}, par: par_oe_q, frame_n: ctl_oe_q,
                       irdy_n: ctl_oe_q, trdy_n: 1'b0, stop_n: 1'b0, devsel_n: 1'b0, perr_n: perr_oe_q,
                       serr_n: 1'b0};
  assign pb.idsel  = idsel_q;
  assign pb.req_n  = req_q;
  assign cmd_busy  = busy_q;
  assign rsp_valid = rv_q;
  assign rsp_stat  = rst_q;
endmodule : pb_host_end

//--- hw/pb_link_if.sv
`timescale 1ns/10ps
interface pb_link_if;
  import pb_pkg::*;
  logic                    pci_clk;
  pb_bus_s                 dev_o;
  pb_bus_s                 dev_oe;
  pb_bus_s                 hst_o;
  pb_bus_s                 hst_oe;
  pb_bus_s                 bus;
  logic                    idsel;
  logic [PB_REQ_W:1]       req_n;
  logic [PB_REQ_W:1]       gnt_n;

  // Wired bus with pull-ups: undriven bits read high
  assign bus = (dev_o | ~dev_oe) & (hst_o | ~hst_oe);

  modport dev (input pci_clk, bus, idsel, req_n, output dev_o, dev_oe, gnt_n);
  modport hst (input pci_clk, bus, gnt_n, output hst_o, hst_oe, idsel, req_n);
endinterface : pb_link_if

//--- hw/pb_pkg.sv
package pb_pkg;
  localparam int PB_AD_W  = 32;
  localparam int PB_CBE_W = 4;
  localparam int PB_REQ_W = 3;

  // Shared bus pins; active-low pins end in _n
  typedef struct packed {
    logic [PB_AD_W-1:0]  ad;
    logic [PB_CBE_W-1:0] cbe_n;
    logic                par;
    logic                frame_n;
    logic                irdy_n;
    logic                trdy_n;
    logic                stop_n;
    logic                devsel_n;
    logic                perr_n;
    logic                serr_n;
  } pb_bus_s;

  localparam int PB_BUS_W = $bits(pb_bus_s);
  // Device sample vector: link clock, select, requests, bus
  localparam int PB_IN_W  = PB_BUS_W + PB_REQ_W + 2;
  localparam int PB_IN_CK = PB_IN_W - 1;
  localparam int PB_IN_ID = PB_IN_W - 2;

  // Bus commands
  localparam logic [3:0] PB_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PB_CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] PB_CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] PB_CMD_CFG_RD  = 4'hA;
  localparam logic [3:0] PB_CMD_CFG_WR  = 4'hB;
  localparam logic [3:0] PB_BE_ALL      = 4'h0;
  localparam int         PB_CMD_WR_BIT  = 0;

  // Address decode
  localparam int          PB_BAR_LSB  = 16;
  localparam logic [15:0] PB_BAR_HI   = 16'h8000;
  localparam logic [1:0]  PB_CFG_TYP0 = 2'h0;
  localparam logic [31:0] PB_CFG_RST  = 32'h0000_0000;

  // Link clocks an initiator waits for a claim
  localparam logic [2:0] PB_DEVSEL_WAIT = 3'h5;
  localparam logic [2:0] PB_REQ_IDLE    = 3'h7;
  localparam logic [2:0] PB_REQ_ONE     = 3'h6;

  typedef enum logic [1:0] {
    PB_ST_OK    = 2'h0,
    PB_ST_RETRY = 2'h1,
    PB_ST_ABORT = 2'h2,
    PB_ST_PERR  = 2'h3
  } pb_stat_e;

  // Even parity over address/data and command/enables
  function automatic logic pb_parity(input logic [PB_AD_W-1:0] ad, input logic [PB_CBE_W-1:0] cbe);
    return ^{ad, cbe};
  endfunction : pb_parity
endpackage : pb_pkg
